// [hw/can_accept_defines.vh]
// Constants for the acceptance filter and mask register block.
// Assumes a 32-bit AXI4-Lite register bus and one 10 MHz clock.
`ifndef CAN_ACCEPT_DEFINES_VH
`define CAN_ACCEPT_DEFINES_VH

// ***************************************************************
// Register map (byte addresses)
// ***************************************************************
`define FILT_BASE 12'h000
`define MASK_BASE 12'h100
`define MODE_ADDR 12'h200
`define STAT_ADDR 12'h204
`define MASK_STRIDE_SHIFT 4
`define FILT_COUNT 5'h10
`define FILT_ALWAYS 5'h06

// ***************************************************************
// Fields
// ***************************************************************
`define SIDL_FRAME_BIT 3
`define SIDL_WR_MASK 8'he3
`define MODE0 2'h0
`define AXI_OKAY 2'h0
`define AXI_DECERR 2'h3
`define ADDR_W 12

`endif

// [hw/filter_ram.v]
// Small memory holding the two extended identifier bytes of the sixteen filters.
// Assumes one clock; read data comes from a register one cycle after the address.
`timescale 1ns/100ps
module filter_ram (
  input wire ref_clk_in,
  input wire wr_en_in,
  input wire [3:0] wr_addr_in,
  input wire [15:0] wr_data_in,
  input wire [1:0] wr_byte_in,
  input wire [3:0] rd_addr_in,
  output reg [15:0] rd_data_out
);
  reg [15:0] mem [0:15];

  // Contents are left without reset, so values stay unknown until written.
  always @(posedge ref_clk_in) begin
    if (wr_en_in && wr_byte_in[0]) begin
      mem[wr_addr_in][7:0] <= wr_data_in[7:0];
    end
    if (wr_en_in && wr_byte_in[1]) begin
      mem[wr_addr_in][15:8] <= wr_data_in[15:8];
    end
    rd_data_out <= mem[rd_addr_in];
  end
endmodule

// [hw/can_acceptance_filter_mask_regs.v]
// Acceptance filter extended bytes, two acceptance masks, and the match logic.
// Assumes an AXI4-Lite master, and a controller feeding identifier, frame format and filter type bits.
`timescale 1ns/100ps
`include "can_accept_defines.vh"
module can_acceptance_filter_mask_regs (
  input wire ref_clk_in,
  input wire reset_in,
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [28:0] rx_id_in,
  input wire rx_ext_in,
  input wire rx_valid_in,
  input wire [15:0] filter_std_id_low_type_in,
  input wire [10:0] filter_std_bits_in,
  input wire [1:0] filter_ext_top_in,
  input wire [3:0] filter_sel_in,
  input wire mask_sel_in,
  output reg accept_out,
  output reg accept_valid_out
);

  // ***************************************************************
  // State
  // ***************************************************************
  reg [1:0] mode_q;
  reg [7:0] mask_std_id_high_q [0:1];
  reg [7:0] mask_std_id_low_q [0:1];
  reg [7:0] mask_ext_id_high_q [0:1];
  reg [7:0] mask_ext_id_low_q [0:1];
  reg frame_type_match_enable_q [0:1];
  reg [11:0] awaddr_q;
  reg aw_held_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg w_held_q;
  reg rd_pend_q;
  reg [11:0] araddr_q;
  reg [28:0] id_q;
  reg ext_q;
  reg type_q;
  reg [10:0] fstd_q;
  reg [1:0] ftop_q;
  reg msel_q;
  reg match_pend_q;
  reg match_filt_ok_q;
  reg [7:0] last_ok_q;
  wire [15:0] ram_rd;
  wire [3:0] ram_rd_addr;

  // ***************************************************************
  // Address decoding
  // ***************************************************************
  // Only the page nibble of each base is compared; the word index sits below it.
  localparam [11:0] FILT_BASE_W = `FILT_BASE;
  localparam [11:0] MASK_BASE_W = `MASK_BASE;
  // Mask decoding ignores address bits 3 and 2, so each mask word also answers
  // at the three words after it; software should use the aligned slot only.

  function filt_hit;
    input [11:0] a;
    begin
      filt_hit = (a[11:8] == FILT_BASE_W[11:8]) && (a[7:6] == 2'h0) && (a[1:0] == 2'h0);
    end
  endfunction

  function mask_hit;
    input [11:0] a;
    begin
      mask_hit = (a[11:8] == MASK_BASE_W[11:8]) && (a[7:5] == 3'h0) && (a[1:0] == 2'h0);
    end
  endfunction

  // A filter above five is absent in Mode 0.
  function filt_present;
    input [3:0] idx;
    input [1:0] mode;
    begin
      filt_present = (mode != `MODE0) || ({1'b0, idx} < `FILT_ALWAYS);
    end
  endfunction

  // The frame-type mask bit is kept in Mode 0 but hidden and ignored there.
  function type_check_on;
    input enable;
    input [1:0] mode;
    begin
      type_check_on = enable && (mode != `MODE0);
    end
  endfunction

  // ***************************************************************
  // Write path
  // ***************************************************************
  wire do_write = aw_held_q && w_held_q && !s_axi_bvalid;
  wire [3:0] w_fidx = awaddr_q[5:2];
  wire w_filt = filt_hit(awaddr_q) && filt_present(w_fidx, mode_q);
  wire w_mask = mask_hit(awaddr_q);
  wire w_midx = awaddr_q[`MASK_STRIDE_SHIFT];
  wire w_mode = (awaddr_q == `MODE_ADDR);
  wire w_ok = w_filt || w_mask || w_mode || (awaddr_q == `STAT_ADDR);
  // An absent filter is dropped here, so a refused write leaves the memory untouched.
  wire ram_wr_en = do_write && w_filt;

  filter_ram u_ram (
    .ref_clk_in(ref_clk_in),
    .wr_en_in(ram_wr_en),
    .wr_addr_in(w_fidx),
    .wr_data_in(wdata_q[15:0]),
    .wr_byte_in(wstrb_q[1:0]),
    .rd_addr_in(ram_rd_addr),
    .rd_data_out(ram_rd)
  );

  always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `AXI_OKAY;
      mode_q <= `MODE0;
      frame_type_match_enable_q[0] <= 1'b0;
      frame_type_match_enable_q[1] <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q <= s_axi_awaddr;
        aw_held_q <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        w_held_q <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= w_ok ? `AXI_OKAY : `AXI_DECERR;
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        // A new mode governs frames judged from the next cycle on.
        if (w_mode && wstrb_q[0]) begin
          mode_q <= wdata_q[1:0];
        end
        // Frame-type bit only writes in modes other than Mode 0.
        if (w_mask && wstrb_q[0] && mode_q != `MODE0) begin
          frame_type_match_enable_q[w_midx] <= wdata_q[`SIDL_FRAME_BIT];
        end
      end
      // Readies come back only once the answer is taken, so a second write
      // can never overtake a response that is still waiting.
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Mask identifier bytes carry no reset so they stay unknown until written.
  always @(posedge ref_clk_in) begin
    if (do_write && w_mask) begin
      if (wstrb_q[0]) begin
        mask_std_id_low_q[w_midx] <= wdata_q[7:0] & `SIDL_WR_MASK;
      end
      if (wstrb_q[1]) begin
        mask_std_id_high_q[w_midx] <= wdata_q[15:8];
      end
      if (wstrb_q[2]) begin
        mask_ext_id_low_q[w_midx] <= wdata_q[23:16];
      end
      if (wstrb_q[3]) begin
        mask_ext_id_high_q[w_midx] <= wdata_q[31:24];
      end
    end
  end

  // ***************************************************************
  // Read path
  // ***************************************************************
  // The matcher borrows the memory port in every cycle except the one in which a read is taken.
  assign ram_rd_addr = (s_axi_arvalid && s_axi_arready) ? s_axi_araddr[5:2] : filter_sel_in;
  wire r_midx = araddr_q[`MASK_STRIDE_SHIFT];
  wire [7:0] sidl_rd = mask_std_id_low_q[r_midx] & `SIDL_WR_MASK;
  // Every read answers two cycles after the take: the memory word is registered,
  // then the answer; the other registers wait too, so the bus sees one fixed latency.

  always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `AXI_OKAY;
      rd_pend_q <= 1'b0;
      araddr_q <= 12'h000;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        araddr_q <= s_axi_araddr;
        rd_pend_q <= 1'b1;
        s_axi_arready <= 1'b0;
      end
      if (rd_pend_q) begin
        rd_pend_q <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `AXI_OKAY;
        s_axi_rdata <= 32'h00000000;
        if (filt_hit(araddr_q)) begin
          if (filt_present(araddr_q[5:2], mode_q)) begin
            s_axi_rdata <= {16'h0000, ram_rd};
          end else begin
            s_axi_rresp <= `AXI_DECERR;
          end
        end else if (mask_hit(araddr_q)) begin
          s_axi_rdata <= {mask_ext_id_high_q[r_midx], mask_ext_id_low_q[r_midx],
                          mask_std_id_high_q[r_midx],
                          sidl_rd[7:4],
                          type_check_on(frame_type_match_enable_q[r_midx], mode_q),
                          sidl_rd[2:0]};
        end else if (araddr_q == `MODE_ADDR) begin
          s_axi_rdata <= {30'h00000000, mode_q};
        end else if (araddr_q == `STAT_ADDR) begin
          s_axi_rdata <= {24'h000000, last_ok_q};
        end else begin
          // Unmapped addresses answer with a decode error and zero data.
          s_axi_rresp <= `AXI_DECERR;
        end
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ***************************************************************
  // Acceptance match
  // ***************************************************************
  // Stage one latches the frame while the memory fetches the filter word.
  // Back-to-back frames are fine: the result registers at the same edge that latches the next frame.
  wire [28:0] fid = {fstd_q, ftop_q, ram_rd};
  wire [28:0] msk = {mask_std_id_high_q[msel_q], mask_std_id_low_q[msel_q][7:5],
                     mask_std_id_low_q[msel_q][1:0], mask_ext_id_high_q[msel_q],
                     mask_ext_id_low_q[msel_q]};
  wire [28:0] cmp_id = ext_q ? id_q : {id_q[10:0], 18'h00000};
  wire [28:0] cmp_msk = ext_q ? msk : {msk[28:18], 18'h00000};
  wire bits_ok = ((cmp_id ^ fid) & cmp_msk) == 29'h00000000;
  wire type_ok = !type_check_on(frame_type_match_enable_q[msel_q], mode_q)
                 || (type_q == ext_q);
  wire match_ok = bits_ok && type_ok && match_filt_ok_q;

  always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      match_pend_q <= 1'b0;
      match_filt_ok_q <= 1'b0;
      id_q <= 29'h00000000;
      ext_q <= 1'b0;
      type_q <= 1'b0;
      fstd_q <= 11'h000;
      ftop_q <= 2'h0;
      msel_q <= 1'b0;
      accept_out <= 1'b0;
      accept_valid_out <= 1'b0;
      last_ok_q <= 8'h00;
    end else begin
      // A frame that meets a bus read take is dropped; the memory port serves the read.
      match_pend_q <= rx_valid_in && !(s_axi_arvalid && s_axi_arready);
      if (rx_valid_in) begin
        id_q <= rx_id_in;
        ext_q <= rx_ext_in;
        type_q <= filter_std_id_low_type_in[filter_sel_in];
        fstd_q <= filter_std_bits_in;
        ftop_q <= filter_ext_top_in;
        msel_q <= mask_sel_in;
        match_filt_ok_q <= filt_present(filter_sel_in, mode_q);
      end
      accept_valid_out <= match_pend_q;
      if (match_pend_q) begin
        accept_out <= match_ok;
        last_ok_q <= {7'h00, match_ok};
      end
    end
  end
endmodule

// [dv/accept_props.sv]
// Checker for bus handshake, read latency and match timing of the register block.
// Assumes it is bound to the block's top ports and sees them unchanged.
`timescale 1ns/100ps
module accept_props (
  input wire ref_clk_in,
  input wire reset_in,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire rx_valid_in,
  input wire accept_out,
  input wire accept_valid_out
);
  // ********
  // Properties
  // ********
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  sequence ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence rd_answer;
    !s_axi_arready ##1 s_axi_rvalid;
  endsequence
  wr_resp_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("write answer dropped early");
  rd_resp_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer changed early");
  rd_latency_a: assert property (ar_take |=> rd_answer) else $error("read answer late");
  aw_busy_a: assert property (
    s_axi_awvalid && s_axi_awready |=> !s_axi_awready) else $error("address ready stayed up");
  unmapped_rd_a: assert property (
    ar_take and s_axi_araddr == 12'hffc |-> ##2 s_axi_rresp == 2'h3 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  match_lat_a: assert property (
    rx_valid_in && !(s_axi_arvalid && s_axi_arready) |-> ##2 accept_valid_out)
    else $error("match result missing");
  match_src_a: assert property (
    accept_valid_out |-> $past(rx_valid_in, 2)) else $error("match result without frame");
  accept_hold_a: assert property (
    !accept_valid_out |-> $stable(accept_out)) else $error("accept changed without result");
endmodule
bind can_acceptance_filter_mask_regs accept_props chk (.ref_clk_in, .reset_in,
  .s_axi_awvalid, .s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .rx_valid_in, .accept_out, .accept_valid_out);

// [dv/can_acceptance_filter_mask_regs_test.sv]
// Testbench: register bus traffic and random frames, checked through expectation queues.
// Assumes the register block and its defines header from hw/.
`timescale 1ns/100ps
module can_acceptance_filter_mask_regs_test;
  // ********
  // Stimulus and scoreboard
  // ********
  reg ref_clk_in = 1'b0, reset_in = 1'b1;
  reg [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  reg [31:0] s_axi_wdata = 32'h0, seed = 32'h56;
  reg [3:0] s_axi_wstrb = 4'hf, filter_sel_in = 4'h0;
  reg s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  reg rx_ext_in = 0, rx_valid_in = 0, mask_sel_in = 0, last_ok = 0;
  reg [28:0] rx_id_in = 0;
  reg [15:0] filter_std_id_low_type_in = 0, fe [0:15];
  reg [10:0] filter_std_bits_in = 0;
  reg [1:0] filter_ext_top_in = 0, mode = 0;
  reg [31:0] mk [0:1];
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire accept_out, accept_valid_out;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  int miscompares = 0, n_tests = 0, wait_n = 0;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic aq[$];
  can_acceptance_filter_mask_regs dut (
    .ref_clk_in(ref_clk_in), .reset_in(reset_in),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .rx_id_in(rx_id_in), .rx_ext_in(rx_ext_in), .rx_valid_in(rx_valid_in),
    .filter_std_id_low_type_in(filter_std_id_low_type_in),
    .filter_std_bits_in(filter_std_bits_in), .filter_ext_top_in(filter_ext_top_in),
    .filter_sel_in(filter_sel_in), .mask_sel_in(mask_sel_in),
    .accept_out(accept_out), .accept_valid_out(accept_valid_out)
  );
  always #50 ref_clk_in = ~ref_clk_in;
  function automatic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task report_and_stop;
    miscompares += rq.size() + bq.size() + aq.size();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input [33:0] seen, input [33:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // A hung handshake counts as a mismatch and ends the run.
  task tick;
    @(posedge ref_clk_in);
    wait_n++;
    if (wait_n > 64) begin
      miscompares++;
      report_and_stop;
    end
  endtask
  always @(posedge ref_clk_in) begin
    if (s_axi_bvalid && s_axi_bready) chk({32'h0, s_axi_bresp}, {32'h0, bq.pop_front()}, "bresp");
    if (s_axi_rvalid && s_axi_rready) chk({s_axi_rdata, s_axi_rresp}, rq.pop_front(), "read");
    if (accept_valid_out) chk({33'h0, accept_out}, {33'h0, aq.pop_front()}, "accept");
  end
  task wr(input [11:0] a, input [31:0] d, input [1:0] e);
    wait_n = 0;
    bq.push_back(e);
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} <= {a, 1'b1, d, 2'b11};
    do begin
      tick;
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 0;
    // One edge passes so the next call never rewrites a ready in the same step.
    @(posedge ref_clk_in);
  endtask
  task rd(input [11:0] a, input [33:0] e);
    wait_n = 0;
    rq.push_back(e);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
    do begin
      tick;
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 0;
    @(posedge ref_clk_in);
  endtask
  // Half the frames are bent onto the filter so that accepts are common.
  // Frames go out back to back: valid stays high and the caller drops it.
  task frame(input [3:0] f, input m);
    reg [31:0] r;
    reg [15:0] ty;
    reg [28:0] id, filt, msk;
    reg ok;
    r = rnd();
    ty = 16'(rnd());
    id = 29'(rnd());
    filt = {r[12:0], fe[f]};
    msk = {mk[m][15:8], mk[m][7:5], mk[m][1:0], mk[m][31:16]};
    if (r[14]) id = r[13] ? filt ^ (id & ~msk)
                          : {18'h0, filt[28:18] ^ (id[10:0] & ~msk[28:18])};
    ok = r[13] ? ((id ^ filt) & msk) == 0 : ((id[10:0] ^ filt[28:18]) & msk[28:18]) == 0;
    if (mk[m][3] && mode != 0 && ty[f] != r[13]) ok = 0;
    last_ok = ok;
    aq.push_back(ok);
    {rx_id_in, rx_ext_in, rx_valid_in, filter_sel_in, mask_sel_in} <= {id, r[13], 1'b1, f, m};
    {filter_std_bits_in, filter_ext_top_in, filter_std_id_low_type_in} <= {r[12:0], ty};
    @(posedge ref_clk_in);
  endtask
  initial begin
    repeat (16) @(posedge ref_clk_in);
    reset_in <= 0;
    @(posedge ref_clk_in);
    rd(12'h200, 34'h0);
    wr(12'h018, 32'h0, 2'h3);
    rd(12'h03c, 34'h3);
    rd(12'hffc, 34'h3);
    wr(12'h100, 32'hffffffff, 2'h0);
    rd(12'h100, {32'hffffffe3, 2'h0});
    wr(12'h200, 32'h1, 2'h0);
    mode = 1;
    wr(12'h100, 32'hffffffff, 2'h0);
    rd(12'h100, {32'hffffffeb, 2'h0});
    for (int i = 0; i < 16; i++) begin
      fe[i] = 16'(rnd());
      wr(12'(i * 4), {16'h0, fe[i]}, 2'h0);
      rd(12'(i * 4), {16'h0, fe[i], 2'h0});
    end
    for (int m = 0; m < 2; m++) begin
      mk[m] = rnd() & 32'hffffffeb;
      wr(12'h100 + 12'(m * 16), mk[m], 2'h0);
      rd(12'h100 + 12'(m * 16), {mk[m], 2'h0});
    end
    for (int k = 2; k >= 0; k--) begin
      mode = 2'(k);
      wr(12'h200, k, 2'h0);
      repeat (12) frame(k ? 4'(rnd() % 16) : 4'(rnd() % 6), seed[7]);
      rx_valid_in <= 0;
    end
    rd(12'h100, {mk[0] & 32'hfffffff7, 2'h0});
    rd(12'h204, {31'h0, last_ok, 2'h0});
    repeat (4) @(posedge ref_clk_in);
    report_and_stop;
  end
endmodule
